// ==== dv/gcs_clock_select_assertions.sv ====
// Checker for the clock selector: output pair, fail-safe, runt guard, power-on.
// Assumes only the top module's ports; bound to every instance below.
`timescale 1ns/1ns
`default_nettype none

module gcs_clock_select_assertions #(
    parameter int POR_CYCLES   = 4,
    parameter int DRAIN_CYCLES = 8
) (
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic i_link_clk,
    input wire logic i_primary_clock_in,
    input wire logic i_primary_clock_in_n,
    input wire logic i_alternate_clock_in,
    input wire logic i_alternate_clock_in_n,
    input wire logic i_source_sel,
    input wire logic i_source_sel_open,
    input wire logic i_init_timing_pin,
    input wire logic o_clk_out,
    input wire logic o_clk_out_n,
    input wire logic o_guard_ready,
    input wire logic o_bypass_mode
);
    logic       eff;
    logic       sp;
    logic       sn;
    logic [7:0] hi_cnt;
    logic [7:0] rel_cnt;
    logic [9:0] dead_cnt;

    // Selected pair; a floating select counts as high
    assign eff = i_source_sel | i_source_sel_open;
    assign sp  = eff ? i_alternate_clock_in : i_primary_clock_in;
    assign sn  = eff ? i_alternate_clock_in_n : i_primary_clock_in_n;

    // Edges with the capacitor pin high, and edges since release
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            hi_cnt  <= 8'h00;
            rel_cnt <= 8'h00;
        end else begin
            hi_cnt  <= i_init_timing_pin ? hi_cnt + 8'h01 : 8'h00;
            rel_cnt <= rel_cnt + 8'h01;
        end
    end
    // Dead time of the selected pair; a new choice restarts it, as a drain may end it
    always_ff @(posedge i_link_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            dead_cnt <= 10'h000;
        end else begin
            dead_cnt <= (sp != sn || $changed(eff)) ? 10'h000 : dead_cnt + 10'h001;
        end
    end

    property p_inv;
        @(posedge i_link_clk) disable iff (!i_arst_n) o_clk_out_n != o_clk_out;
    endproperty
    a_inv: assert property (p_inv) else $error("output legs equal");
    property p_follow;
        @(posedge i_link_clk) disable iff (!i_arst_n)
        $past(o_bypass_mode, 4) && $past(sp, 3) != $past(sn, 3) |-> o_clk_out == $past(sp, 3);
    endproperty
    a_follow: assert property (p_follow) else $error("mux output wrong");
    property p_open;
        @(posedge i_link_clk) disable iff (!i_arst_n)
        $past(o_bypass_mode, 4) && $past(i_source_sel_open, 3)
        && $past(i_alternate_clock_in, 3) && !$past(i_alternate_clock_in_n, 3) |-> o_clk_out;
    endproperty
    a_open: assert property (p_open) else $error("open select not alternate");
    property p_hold;
        @(posedge i_link_clk) disable iff (!i_arst_n)
        dead_cnt > DRAIN_CYCLES + 6 |-> $stable(o_clk_out);
    endproperty
    a_hold: assert property (p_hold) else $error("dead input toggles output");
    property p_runt_hi;
        @(posedge i_link_clk) disable iff (!i_arst_n)
        o_guard_ready && $rose(o_clk_out) |-> o_clk_out [*4];
    endproperty
    a_runt_hi: assert property (p_runt_hi) else $error("short high pulse");
    property p_runt_lo;
        @(posedge i_link_clk) disable iff (!i_arst_n)
        o_guard_ready && $fell(o_clk_out) |-> !o_clk_out [*2];
    endproperty
    a_runt_lo: assert property (p_runt_lo) else $error("short low phase");
    property p_por_wait;
        @(posedge i_sys_clk) disable iff (!i_arst_n) $rose(o_guard_ready) |-> hi_cnt >= POR_CYCLES;
    endproperty
    a_por_wait: assert property (p_por_wait) else $error("guard ready too early");
    property p_strap;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        $rose(o_bypass_mode) |-> rel_cnt <= 8'h04 && $past(i_init_timing_pin, 3) && !o_guard_ready;
    endproperty
    a_strap: assert property (p_strap) else $error("bypass without strap");

    c_ready: cover property (@(posedge i_sys_clk) $rose(o_guard_ready));
    c_bypass: cover property (@(posedge i_sys_clk) $rose(o_bypass_mode));
    c_dead: cover property (@(posedge i_link_clk) dead_cnt == DRAIN_CYCLES + 7);
endmodule

bind gcs_clock_select gcs_clock_select_assertions #(
    .POR_CYCLES(POR_CYCLES), .DRAIN_CYCLES(DRAIN_CYCLES)
) u_chk (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_link_clk(i_link_clk),
    .i_primary_clock_in(i_primary_clock_in), .i_primary_clock_in_n(i_primary_clock_in_n),
    .i_alternate_clock_in(i_alternate_clock_in),
    .i_alternate_clock_in_n(i_alternate_clock_in_n), .i_source_sel(i_source_sel),
    .i_source_sel_open(i_source_sel_open), .i_init_timing_pin(i_init_timing_pin),
    .o_clk_out(o_clk_out), .o_clk_out_n(o_clk_out_n), .o_guard_ready(o_guard_ready),
    .o_bypass_mode(o_bypass_mode)
);
`default_nettype wire

// ==== dv/gcs_src_model.sv ====
// Model of one differential clock source that can fail to a DC level.
// Assumes the bench raises i_dead or i_stall_hi; a fault starts at a phase boundary.
`timescale 1ns/1ns
`default_nettype none

module gcs_src_model #(
    parameter int HALF_NS = 60
) (
    input  wire logic i_dead,
    input  wire logic i_stall_hi,
    output logic      o_p,
    output logic      o_n
);
    logic ph     = 1'b0;
    logic dead_q = 1'b0;

    // Fault taken as a rise is due, so the last phase seen is a full low
    always #(HALF_NS) begin
        if (!ph) begin
            dead_q = i_dead;
        end
        // A stall freezes the pair in its high phase: a live but stopped level
        if (!(i_stall_hi && ph)) begin
            ph = ~ph;
        end
    end
    // A dead pair shows both legs low, no swing at all
    assign o_p = ph & ~dead_q;
    assign o_n = ~ph & ~dead_q;
endmodule
`default_nettype wire

// ==== dv/tb_glitchless_clock_select.sv ====
// Bench for the clock selector: power-on, follow, switch, fail-safe, bypass.
// Assumes the source model and the bound checker; edges never coincide.
`timescale 1ns/1ns
`default_nettype none

module tb_glitchless_clock_select;
    localparam int POR = 4;
    logic sys_clk  = 1'b0;
    logic link_clk = 1'b0;
    logic arst_n   = 1'b0;
    logic sel      = 1'b0;
    logic sel_open = 1'b0;
    logic pin      = 1'b0;
    logic pri_dead = 1'b0;
    logic alt_dead = 1'b0;
    logic pri_stall = 1'b0;
    logic pp, pn, ap, an, co, con, ready, bypass;
    int   mismatches = 0;
    int   compares   = 0;

    gcs_src_model #(.HALF_NS(60)) u_pri (.i_dead(pri_dead), .i_stall_hi(pri_stall),
        .o_p(pp), .o_n(pn));
    gcs_src_model #(.HALF_NS(84)) u_alt (.i_dead(alt_dead), .i_stall_hi(1'b0),
        .o_p(ap), .o_n(an));
    gcs_clock_select #(.POR_CYCLES(POR), .DRAIN_CYCLES(8)) uut (
        .i_sys_clk(sys_clk), .i_arst_n(arst_n), .i_link_clk(link_clk),
        .i_primary_clock_in(pp), .i_primary_clock_in_n(pn), .i_alternate_clock_in(ap),
        .i_alternate_clock_in_n(an), .i_source_sel(sel), .i_source_sel_open(sel_open),
        .i_init_timing_pin(pin), .o_clk_out(co), .o_clk_out_n(con), .o_guard_ready(ready),
        .o_bypass_mode(bypass));

    // System clock 20 ns; link clock 12 ns, offset so no edges meet
    always #10 sys_clk = ~sys_clk;
    initial begin
        #1;
        forever #6 link_clk = ~link_clk;
    end

    task automatic check(input logic ok, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task automatic do_reset(input logic p);
        step(1);
        arst_n = 1'b0;
        pin    = p;
        step(4);
        arst_n = 1'b1;
    endtask
    // Count output rises over 196 link cycles once the choice has settled
    task automatic rate(input logic s, input logic o, input int lo, input int hi);
        int   n;
        logic prev;
        n = 0;
        step(1);
        sel      = s;
        sel_open = o;
        repeat (30) @(posedge link_clk);
        prev = co;
        repeat (196) begin
            @(negedge link_clk);
            n    = n + int'(prev === 1'b0 && co === 1'b1);
            prev = co;
        end
        check(n >= lo && n <= hi, n, lo);
        check(con === !co, con, !co);
    endtask
    task automatic t_power_on();
        int c;
        c = 0;
        do_reset(1'b0);
        step(20);
        check(ready === 1'b0 && bypass === 1'b0 && co === 1'b0, {ready, bypass, co}, 0);
        pin = 1'b1;
        while (ready !== 1'b1 && c < 200) begin
            step(1);
            c++;
        end
        check(c >= POR && c <= POR + 6, c, POR);
        check(bypass === 1'b0, bypass, 0);
        if (c >= 200) begin
            conclude();
        end
    endtask
    // Guarded: follow, ignore the other pair, fail-safe, rapid switching
    task automatic t_guarded();
        rate(1'b0, 1'b0, 19, 20);
        rate(1'b1, 1'b0, 13, 15);
        rate(1'b0, 1'b1, 13, 15);
        alt_dead = 1'b1;
        rate(1'b0, 1'b0, 19, 20);
        alt_dead = 1'b0;
        pri_dead = 1'b1;
        rate(1'b0, 1'b0, 0, 0);
        rate(1'b1, 1'b0, 13, 15);
        pri_dead = 1'b0;
        for (int i = 0; i < 12; i++) begin
            repeat (7) @(posedge link_clk);
            #2;
            sel = ~sel;
        end
        rate(1'b0, 1'b0, 19, 20);
        // Old clock stopped high: the drain limit must end the phase and move on
        pri_stall = 1'b1;
        step(10);
        check(co === 1'b1, co, 1);
        rate(1'b1, 1'b0, 13, 15);
        pri_stall = 1'b0;
    endtask
    task automatic t_bypass();
        do_reset(1'b1);
        step(10);
        check(bypass === 1'b1 && ready === 1'b0, {bypass, ready}, 2);
        pin = 1'b0;
        rate(1'b0, 1'b0, 19, 20);
        check(bypass === 1'b1, bypass, 1);
        rate(1'b0, 1'b1, 13, 15);
        pri_dead = 1'b1;
        rate(1'b0, 1'b0, 0, 0);
    endtask

    initial begin
        t_power_on();
        t_guarded();
        t_bypass();
        conclude();
    end
endmodule
`default_nettype wire

// ==== hdl/gcs_clock_select.sv ====
// Glitch-free two-source clock selector with fail-safe hold and power-on init.
// Assumes source clocks well below half the link sampling clock; all pins async.
`timescale 1ns/1ns
`default_nettype none

module gcs_clock_select #(
    parameter int POR_CYCLES   = gcs_pkg::GCS_POR_CYCLES,
    parameter int DRAIN_CYCLES = gcs_pkg::GCS_DRAIN_CYCLES
) (
    input  wire logic i_sys_clk,
    input  wire logic i_arst_n,
    input  wire logic i_link_clk,
    input  wire logic i_primary_clock_in,
    input  wire logic i_primary_clock_in_n,
    input  wire logic i_alternate_clock_in,
    input  wire logic i_alternate_clock_in_n,
    input  wire logic i_source_sel,
    input  wire logic i_source_sel_open,
    input  wire logic i_init_timing_pin,
    output logic      o_clk_out,
    output logic      o_clk_out_n,
    output logic      o_guard_ready,
    output logic      o_bypass_mode
);

    localparam int CW = gcs_pkg::GCS_CNT_W;

    generate
        if (POR_CYCLES < 1 || POR_CYCLES >= (1 << CW)) begin : g_bad_por
            $error("gcs_clock_select: POR_CYCLES out of range");
        end
        if (DRAIN_CYCLES < 1 || DRAIN_CYCLES >= (1 << CW)) begin : g_bad_drain
            $error("gcs_clock_select: DRAIN_CYCLES out of range");
        end
    endgenerate

    // ---------------- System clock domain: power-on sequencer ----------------

    logic              init_sync;
    gcs_pkg::gcs_por_t por_state_reg;
    logic [CW-1:0]     por_cnt_reg;

    // Init pin is a pin, so it is synchronised before use
    gcs_sync2 #(.WIDTH(1)) u_init_sync (
        .i_clk    (i_sys_clk),
        .i_arst_n (i_arst_n),
        .i_async  (i_init_timing_pin),
        .o_sync   (init_sync)
    );

    // Strap check, capacitor charge wait, then a minimum settle time
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            por_state_reg <= gcs_pkg::GCS_POR_STRAP;
            por_cnt_reg   <= '0;
            o_bypass_mode <= 1'b0;
            o_guard_ready <= 1'b0;
        end else begin
            case (por_state_reg)
                gcs_pkg::GCS_POR_STRAP: begin
                    if (por_cnt_reg == CW'(gcs_pkg::GCS_STRAP_CYCLES)) begin
                        por_cnt_reg <= '0;
                        // A pin already high this early is tied to the supply
                        if (init_sync) begin
                            o_bypass_mode <= 1'b1;
                            por_state_reg <= gcs_pkg::GCS_POR_DONE;
                        end else begin
                            por_state_reg <= gcs_pkg::GCS_POR_CHARGE;
                        end
                    end else begin
                        por_cnt_reg <= por_cnt_reg + CW'(1);
                    end
                end
                gcs_pkg::GCS_POR_CHARGE: begin
                    if (init_sync) begin
                        por_state_reg <= gcs_pkg::GCS_POR_SETTLE;
                    end
                end
                gcs_pkg::GCS_POR_SETTLE: begin
                    if (por_cnt_reg == CW'(POR_CYCLES - 1)) begin
                        o_guard_ready <= 1'b1;
                        por_state_reg <= gcs_pkg::GCS_POR_DONE;
                    end else begin
                        por_cnt_reg <= por_cnt_reg + CW'(1);
                    end
                end
                default: begin
                    por_state_reg <= gcs_pkg::GCS_POR_DONE;
                end
            endcase
        end
    end

    // ---------------- Link clock domain: guard and output ----------------

    logic                link_arst_n;
    gcs_pkg::gcs_pair_t  prim_s;
    gcs_pkg::gcs_pair_t  alt_s;
    logic                sel_s;
    logic                sel_open_s;
    logic                ready_s;
    logic                bypass_s;
    logic                sel_eff;
    logic                prim_ok;
    logic                alt_ok;
    logic                new_ok;
    logic                new_lvl;
    logic                old_ok;
    logic                old_lvl;
    logic                active_reg;
    gcs_pkg::gcs_guard_t guard_state_reg;
    logic [CW-1:0]       drain_cnt_reg;
    logic                out_reg;
    logic [7:0]          link_s;

    // Reset asserts at once and releases in step with the link clock
    gcs_sync2 #(.WIDTH(1)) u_link_rst (
        .i_clk    (i_link_clk),
        .i_arst_n (i_arst_n),
        .i_async  (1'b1),
        .o_sync   (link_arst_n)
    );

    // Pins and sys-domain levels cross into the link domain together
    // One flop bank for all lanes keeps both legs of a pair in step
    gcs_sync2 #(.WIDTH(8)) u_link_sync (
        .i_clk    (i_link_clk),
        .i_arst_n (link_arst_n),
        .i_async  ({i_primary_clock_in, i_primary_clock_in_n,
                    i_alternate_clock_in, i_alternate_clock_in_n,
                    i_source_sel, i_source_sel_open, o_guard_ready, o_bypass_mode}),
        .o_sync   (link_s)
    );

    // Source choice and pair health; equal legs mean the clock died to DC
    always_comb begin
        {prim_s, alt_s, sel_s, sel_open_s, ready_s, bypass_s} = link_s;
        sel_eff = sel_s | sel_open_s;
        prim_ok = prim_s.p ^ prim_s.n;
        alt_ok  = alt_s.p ^ alt_s.n;
        new_ok  = (sel_eff == gcs_pkg::GCS_SEL_ALTERNATE) ? alt_ok : prim_ok;
        new_lvl = (sel_eff == gcs_pkg::GCS_SEL_ALTERNATE) ? alt_s.p : prim_s.p;
        old_ok  = (active_reg == gcs_pkg::GCS_SEL_ALTERNATE) ? alt_ok : prim_ok;
        old_lvl = (active_reg == gcs_pkg::GCS_SEL_ALTERNATE) ? alt_s.p : prim_s.p;
    end

    // Guard state machine; the output is a flop so no decode glitch escapes
    always_ff @(posedge i_link_clk or negedge link_arst_n) begin
        if (!link_arst_n) begin
            guard_state_reg <= gcs_pkg::GCS_G_HOLD;
            active_reg      <= gcs_pkg::GCS_SEL_PRIMARY;
            drain_cnt_reg   <= '0;
            out_reg         <= 1'b0;
        end else if (bypass_s) begin
            // Plain mux: follows the chosen pair, still holding on a dead input
            active_reg <= sel_eff;
            if (new_ok) begin
                out_reg <= new_lvl;
            end
        end else begin
            case (guard_state_reg)
                gcs_pkg::GCS_G_HOLD: begin
                    // Known state: low output until the power-on sequence ends
                    out_reg <= 1'b0;
                    if (ready_s) begin
                        active_reg      <= sel_eff;
                        guard_state_reg <= gcs_pkg::GCS_G_PARK;
                    end
                end
                gcs_pkg::GCS_G_FOLLOW: begin
                    if (sel_eff != active_reg) begin
                        drain_cnt_reg   <= '0;
                        guard_state_reg <= gcs_pkg::GCS_G_DRAIN;
                    end else if (old_ok) begin
                        out_reg <= old_lvl;
                    end
                end
                gcs_pkg::GCS_G_DRAIN: begin
                    // Let the old high phase finish before parking low
                    drain_cnt_reg <= drain_cnt_reg + CW'(1);
                    if ((old_ok && !old_lvl) || !out_reg) begin
                        out_reg         <= 1'b0;
                        active_reg      <= sel_eff;
                        guard_state_reg <= gcs_pkg::GCS_G_PARK;
                    end else if (drain_cnt_reg == CW'(DRAIN_CYCLES - 1)) begin
                        // Old clock stuck high: end the phase rather than hang
                        out_reg         <= 1'b0;
                        active_reg      <= sel_eff;
                        guard_state_reg <= gcs_pkg::GCS_G_PARK;
                    end else if (old_ok) begin
                        out_reg <= old_lvl;
                    end
                end
                default: begin
                    // Parked low until the new clock is live and low
                    out_reg    <= 1'b0;
                    active_reg <= sel_eff;
                    if (new_ok && !new_lvl && sel_eff == active_reg) begin
                        guard_state_reg <= gcs_pkg::GCS_G_FOLLOW;
                    end
                end
            endcase
        end
    end

    // Differential output drive
    assign o_clk_out   = out_reg;
    assign o_clk_out_n = ~out_reg;

endmodule

`default_nettype wire

// ==== hdl/gcs_pkg.sv ====
// Package for the glitch-free two-source clock selector.
// Holds the pin-pair type, the state encodings and the timing constants.
// Assumes a 50 MHz system clock and a faster free-running link sampling clock.
package gcs_pkg;

    // One differential input pair as seen at the pins
    typedef struct packed {
        logic p;
        logic n;
    } gcs_pair_t;

    // Source select encodings
    localparam logic GCS_SEL_PRIMARY   = 1'b0;
    localparam logic GCS_SEL_ALTERNATE = 1'b1;

    // Power-on sequencer states (system clock domain)
    typedef enum logic [1:0] {
        GCS_POR_STRAP,
        GCS_POR_CHARGE,
        GCS_POR_SETTLE,
        GCS_POR_DONE
    } gcs_por_t;

    // Switchover guard states (link clock domain)
    typedef enum logic [1:0] {
        GCS_G_HOLD,
        GCS_G_FOLLOW,
        GCS_G_DRAIN,
        GCS_G_PARK
    } gcs_guard_t;

    // Clock rates
    localparam int GCS_SYS_PERIOD_NS  = 20;
    localparam int GCS_LINK_PERIOD_NS = 12;

    // Strap sample point: synchroniser latency after reset release
    localparam int GCS_STRAP_CYCLES = 2;

    // Least settle time after the timing capacitor has charged
    localparam int GCS_POR_MIN_NS = 1000;
    localparam int GCS_POR_CYCLES =
        (GCS_POR_MIN_NS + GCS_SYS_PERIOD_NS - 1) / GCS_SYS_PERIOD_NS;

    // Longest wait for a dead old clock to finish its high phase
    localparam int GCS_DRAIN_MAX_NS = 2000;
    localparam int GCS_DRAIN_CYCLES = GCS_DRAIN_MAX_NS / GCS_LINK_PERIOD_NS;

    // Counter width shared by both counters
    localparam int GCS_CNT_W = 16;

endpackage

// ==== hdl/gcs_sync2.sv ====
// Two-flop level synchroniser, one lane per bit.
// Assumes each lane is a level that stays put for several destination clocks.
`timescale 1ns/1ns
`default_nettype none

module gcs_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_arst_n,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] stage1_reg;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("gcs_sync2: WIDTH must be at least 1");
        end
    endgenerate

    // First stage is read by the second stage only
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            stage1_reg <= '0;
            o_sync     <= '0;
        end else begin
            stage1_reg <= i_async;
            o_sync     <= stage1_reg;
        end
    end

endmodule

`default_nettype wire
